// ==== design/wfm_matcher.sv ====
`include "wfm_params.svh"
`default_nettype none
module wfm_matcher #(
    parameter int NUM_FILTERS = 4
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        rx_valid,
    input  wire logic        rx_sof,
    input  wire logic        rx_eof,
    input  wire logic [7:0]  rx_data,
    output logic             rx_normal_enable,
    output logic             magic_detect_active,
    output logic             irq,
    output logic             power_event_output
);
    typedef struct packed {
        logic [31:0]                    ctrl;
        logic [NUM_FILTERS-1:0][30:0]   mask;
        logic [NUM_FILTERS-1:0][3:0]    cmd;
        logic [NUM_FILTERS-1:0][7:0]    offs;
        logic [NUM_FILTERS-1:0][15:0]   crc_exp;
        logic [2:0]                     load_idx;
        logic [31:0]                    mac_lo;
        logic [15:0]                    mac_hi;
        logic                           status;
        logic                           irq_en;
        logic [31:0]                    rdata;
        wfm_pkg::wfm_state_e            state;
        logic [7:0]                     pos;
        logic [47:0]                    dest;
        logic [NUM_FILTERS-1:0][15:0]   crc;
        logic                           power_event;
    } wfm_state_s;

    wfm_state_s cur;
    wfm_state_s next_cur;

    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int b = 0; b < 8; b++) begin
            if (r[15] ^ d[b]) begin
                r = {r[14:0], 1'b0} ^ `WFM_CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    logic        detect_on;
    logic        station_hit;
    logic        broadcast_disable_hit;
    logic        mcast;
    logic [NUM_FILTERS-1:0] filt_match;
    logic [NUM_FILTERS-1:0][15:0] crc_step;

    // low-power state forces detection on
    assign detect_on = cur.ctrl[`WFM_CTL_ENABLE] | cur.ctrl[`WFM_CTL_LOWPOWER];
    assign rx_normal_enable = ~detect_on;
    assign magic_detect_active = cur.ctrl[`WFM_CTL_MAGIC] | cur.ctrl[`WFM_CTL_LOWPOWER];
    assign station_hit = cur.dest == {cur.mac_hi, cur.mac_lo};
    assign broadcast_disable_hit = &cur.dest;
    assign mcast = cur.dest[40];

    genvar g;
    generate
        for (g = 0; g < NUM_FILTERS; g++) begin : g_filt
            logic [8:0] rel;
            assign rel = {1'b0, cur.pos} - {1'b0, cur.offs[g]};
            // masked byte window feeds the crc in frame order
            assign crc_step[g] = (cur.pos >= cur.offs[g] && rel < 9'(`WFM_MASK_BITS)
                                  && cur.mask[g][rel[4:0]]) ? crc16_byte(cur.crc[g], rx_data)
                                                            : cur.crc[g];
            // broadcast passes as multicast, broadcast_disable not consulted
            assign filt_match[g] = cur.cmd[g][`WFM_CMD_ENABLE]
                && (cur.cmd[g][`WFM_CMD_MCAST] ? mcast : station_hit)
                && (cur.crc[g] == cur.crc_exp[g]);
        end
    endgenerate

    always_comb begin
        next_cur = cur;
        next_cur.rdata = 32'h00000000;
        if (reg_wr) begin
            case (reg_addr)
                `WFM_OFF_CTRL: next_cur.ctrl = reg_wdata;
                `WFM_OFF_FILTER: begin
                    // sequential table load
                    case (cur.load_idx)
                        3'h0, 3'h1, 3'h2, 3'h3: next_cur.mask[cur.load_idx[1:0]] = reg_wdata[30:0];
                        3'h4: begin
                            for (int i = 0; i < NUM_FILTERS; i++) begin
                                next_cur.cmd[i] = reg_wdata[8*i +: 4];
                            end
                        end
                        3'h5: begin
                            for (int i = 0; i < NUM_FILTERS; i++) begin
                                next_cur.offs[i] = reg_wdata[8*i +: 8];
                            end
                        end
                        3'h6: begin
                            next_cur.crc_exp[0] = reg_wdata[15:0];
                            next_cur.crc_exp[1] = reg_wdata[31:16];
                        end
                        default: begin
                            next_cur.crc_exp[2] = reg_wdata[15:0];
                            next_cur.crc_exp[3] = reg_wdata[31:16];
                        end
                    endcase
                    next_cur.load_idx = cur.load_idx + 3'h1;
                end
                `WFM_OFF_IRQ_EN: next_cur.irq_en = reg_wdata[0];
                `WFM_OFF_IRQ_CLR: if (reg_wdata[`WFM_ST_FRAME_RX]) next_cur.status = 1'b0;
                `WFM_OFF_MAC_LO: next_cur.mac_lo = reg_wdata;
                `WFM_OFF_MAC_HI: next_cur.mac_hi = reg_wdata[15:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `WFM_OFF_CTRL: next_cur.rdata = cur.ctrl;
                `WFM_OFF_FILTER: next_cur.rdata = {29'h00000000, cur.load_idx};
                `WFM_OFF_STATUS: next_cur.rdata = {31'h00000000, cur.status};
                `WFM_OFF_IRQ_EN: next_cur.rdata = {31'h00000000, cur.irq_en};
                `WFM_OFF_MAC_LO: next_cur.rdata = cur.mac_lo;
                `WFM_OFF_MAC_HI: next_cur.rdata = {16'h0000, cur.mac_hi};
                default: next_cur.rdata = 32'h00000000;
            endcase
        end
        case (cur.state)
            wfm_pkg::WFM_IDLE: begin
                if (detect_on && rx_valid && rx_sof) begin
                    next_cur.state = wfm_pkg::WFM_BODY;
                    next_cur.pos = 8'h01;
                    next_cur.dest = {rx_data, 40'h0000000000};
                    for (int i = 0; i < NUM_FILTERS; i++) begin
                        next_cur.crc[i] = `WFM_CRC_INIT;
                    end
                end
            end
            wfm_pkg::WFM_BODY: begin
                if (!detect_on) begin
                    next_cur.state = wfm_pkg::WFM_IDLE;
                end else if (rx_valid) begin
                    if (cur.pos < 8'h06) begin
                        next_cur.dest[8*(5-cur.pos[2:0]) +: 8] = rx_data;
                    end
                    next_cur.crc = crc_step;
                    if (cur.pos != 8'hFF) begin
                        next_cur.pos = cur.pos + 8'h01;
                    end
                    if (rx_eof) begin
                        next_cur.state = wfm_pkg::WFM_DONE;
                    end
                end
            end
            wfm_pkg::WFM_DONE: begin
                next_cur.state = wfm_pkg::WFM_IDLE;
                if (|filt_match) begin
                    next_cur.status = 1'b1;
                    if (cur.ctrl[`WFM_CTL_USE_PME]) begin
                        next_cur.power_event = 1'b1;
                    end
                end
            end
            default: next_cur.state = wfm_pkg::WFM_IDLE;
        endcase
        if (!detect_on) begin
            next_cur.power_event = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
            cur.ctrl <= `WFM_CTRL_RESET;
            cur.state <= wfm_pkg::WFM_IDLE;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    assign reg_rdata = cur.rdata;
    assign irq = cur.status & cur.irq_en & ~cur.ctrl[`WFM_CTL_USE_PME];
    assign power_event_output = cur.power_event;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    rx_gate_a: assert property (cur.ctrl[`WFM_CTL_ENABLE] |-> !rx_normal_enable)
        else $error("normal rx not blocked");
    rx_resume_a: assert property (!cur.ctrl[`WFM_CTL_ENABLE] && !cur.ctrl[`WFM_CTL_LOWPOWER] |-> rx_normal_enable)
        else $error("normal rx not resumed");
    status_set_a: assert property (clk_en && cur.state == wfm_pkg::WFM_DONE && |filt_match |=> cur.status)
        else $error("status not set");
    irq_path_a: assert property (irq |-> cur.status && cur.irq_en && !cur.ctrl[`WFM_CTL_USE_PME])
        else $error("irq wrong");
    lowpower_force_a: assert property (cur.ctrl[`WFM_CTL_LOWPOWER] |-> magic_detect_active && !rx_normal_enable)
        else $error("low power not forced");
    disabled_filter_a: assert property (!cur.cmd[0][`WFM_CMD_ENABLE] |-> !filt_match[0])
        else $error("disabled filter matched");
    crc_init_a: assert property (clk_en && cur.state == wfm_pkg::WFM_IDLE && detect_on && rx_valid && rx_sof
        |=> cur.crc[0] == `WFM_CRC_INIT)
        else $error("crc not reset");
    load_step_a: assert property (clk_en && reg_wr && reg_addr == `WFM_OFF_FILTER
        |=> cur.load_idx == $past(cur.load_idx) + 3'h1)
        else $error("load index stuck");
    unicast_a: assert property (filt_match[0] && !cur.cmd[0][`WFM_CMD_MCAST] |-> station_hit)
        else $error("unicast type wrong");

    status_keep_a: assert property (clk_en && cur.status
        && !(reg_wr && hit(reg_addr, `WFM_OFF_IRQ_CLR) && reg_wdata[`WFM_ST_FRAME_RX]) |=> cur.status)
        else $error("status lost");
    status_clear_a: assert property (clk_en && reg_wr && hit(reg_addr, `WFM_OFF_IRQ_CLR)
        && reg_wdata[`WFM_ST_FRAME_RX] && !(cur.state == wfm_pkg::WFM_DONE && |filt_match) |=> !cur.status)
        else $error("status not cleared");
    status_cause_a: assert property (clk_en && !cur.status
        && !(cur.state == wfm_pkg::WFM_DONE && |filt_match) |=> !cur.status)
        else $error("status set without match");
    irq_clear_a: assert property (!cur.status |-> !irq)
        else $error("irq without status");
    pme_select_a: assert property (clk_en && !power_event_output && !cur.ctrl[`WFM_CTL_USE_PME]
        |=> !power_event_output)
        else $error("power event without select");
    pme_set_a: assert property (clk_en && detect_on && cur.state == wfm_pkg::WFM_DONE && |filt_match
        && cur.ctrl[`WFM_CTL_USE_PME] |=> power_event_output)
        else $error("power event missing");
    pme_drop_a: assert property (clk_en && !detect_on |=> !power_event_output)
        else $error("power event kept");

    idle_hold_a: assert property (clk_en && cur.state == wfm_pkg::WFM_IDLE && !detect_on
        |=> cur.state == wfm_pkg::WFM_IDLE)
        else $error("frame taken while off");
    sof_start_a: assert property (clk_en && cur.state == wfm_pkg::WFM_IDLE && detect_on
        && rx_valid && rx_sof |=> cur.state == wfm_pkg::WFM_BODY && cur.pos == 8'h01)
        else $error("frame start missed");
    dest_capture_a: assert property (clk_en && detect_on && cur.state == wfm_pkg::WFM_BODY
        && rx_valid && cur.pos == 8'h05 |=> cur.dest[7:0] == $past(rx_data))
        else $error("destination byte lost");
    eof_done_a: assert property (clk_en && detect_on && cur.state == wfm_pkg::WFM_BODY
        && rx_valid && rx_eof |=> cur.state == wfm_pkg::WFM_DONE)
        else $error("frame end missed");
    abort_a: assert property (clk_en && cur.state == wfm_pkg::WFM_BODY && !detect_on
        |=> cur.state == wfm_pkg::WFM_IDLE)
        else $error("frame not aborted");
    done_exit_a: assert property (clk_en && cur.state == wfm_pkg::WFM_DONE |=> cur.state == wfm_pkg::WFM_IDLE)
        else $error("done state stuck");
    freeze_a: assert property (!clk_en |=> $stable(cur))
        else $error("state moved while frozen");

    bus_idle_a: assert property (clk_en && !reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data not idle");
    ctrl_write_a: assert property (clk_en && reg_wr && hit(reg_addr, `WFM_OFF_CTRL)
        |=> cur.ctrl == $past(reg_wdata))
        else $error("control write lost");
    irq_en_write_a: assert property (clk_en && reg_wr && hit(reg_addr, `WFM_OFF_IRQ_EN)
        |=> cur.irq_en == $past(reg_wdata[0]))
        else $error("irq enable write lost");
    mac_lo_write_a: assert property (clk_en && reg_wr && hit(reg_addr, `WFM_OFF_MAC_LO)
        |=> cur.mac_lo == $past(reg_wdata))
        else $error("station low write lost");
    mac_hi_write_a: assert property (clk_en && reg_wr && hit(reg_addr, `WFM_OFF_MAC_HI)
        |=> cur.mac_hi == $past(reg_wdata[15:0]))
        else $error("station high write lost");
    status_read_a: assert property (clk_en && reg_rd && hit(reg_addr, `WFM_OFF_STATUS)
        |=> reg_rdata == {31'h00000000, $past(cur.status)})
        else $error("status read wrong");
    index_read_a: assert property (clk_en && reg_rd && hit(reg_addr, `WFM_OFF_FILTER)
        |=> reg_rdata == {29'h00000000, $past(cur.load_idx)})
        else $error("load index read wrong");
    load_mask_a: assert property (clk_en && reg_wr && hit(reg_addr, `WFM_OFF_FILTER) && cur.load_idx == 3'h0
        |=> cur.mask[0] == $past(reg_wdata[30:0]))
        else $error("mask word misplaced");
    load_cmd_a: assert property (clk_en && reg_wr && hit(reg_addr, `WFM_OFF_FILTER) && cur.load_idx == 3'h4
        |=> cur.cmd[0] == $past(reg_wdata[3:0]))
        else $error("command word misplaced");
    load_off_a: assert property (clk_en && reg_wr && hit(reg_addr, `WFM_OFF_FILTER) && cur.load_idx == 3'h5
        |=> cur.offs[0] == $past(reg_wdata[7:0]))
        else $error("offset word misplaced");
    load_crc_lo_a: assert property (clk_en && reg_wr && hit(reg_addr, `WFM_OFF_FILTER) && cur.load_idx == 3'h6
        |=> cur.crc_exp[1] == $past(reg_wdata[31:16]))
        else $error("first crc word misplaced");
    load_crc_hi_a: assert property (clk_en && reg_wr && hit(reg_addr, `WFM_OFF_FILTER) && cur.load_idx == 3'h7
        |=> cur.crc_exp[3] == $past(reg_wdata[31:16]))
        else $error("second crc word misplaced");

    // per-filter checks
    generate
        for (g = 0; g < NUM_FILTERS; g++) begin : g_chk
            filt_off_a: assert property (!cur.cmd[g][`WFM_CMD_ENABLE] |-> !filt_match[g])
                else $error("disabled filter matched");
            filt_type_a: assert property (filt_match[g]
                |-> (cur.cmd[g][`WFM_CMD_MCAST] ? mcast : station_hit))
                else $error("address type ignored");
            filt_crc_a: assert property (filt_match[g] |-> cur.crc[g] == cur.crc_exp[g])
                else $error("crc mismatch matched");
            filt_skip_a: assert property (clk_en && detect_on && cur.state == wfm_pkg::WFM_BODY && rx_valid
                && cur.pos < cur.offs[g] |=> $stable(cur.crc[g]))
                else $error("byte before offset entered crc");
            filt_window_a: assert property (clk_en && detect_on && cur.state == wfm_pkg::WFM_BODY && rx_valid
                && {1'b0, cur.pos} >= {1'b0, cur.offs[g]} + 9'h01F |=> $stable(cur.crc[g]))
                else $error("byte past mask entered crc");
            filt_broadcast_disable_a: assert property (cur.cmd[g][`WFM_CMD_ENABLE] && cur.cmd[g][`WFM_CMD_MCAST]
                && broadcast_disable_hit && cur.crc[g] == cur.crc_exp[g] |-> filt_match[g])
                else $error("broadcast wake frame refused");
        end
    endgenerate

    match_c: cover property (cur.state == wfm_pkg::WFM_DONE && |filt_match);
    pme_c: cover property (power_event_output);
    irq_c: cover property (irq);
    broadcast_disable_c: cover property (cur.state == wfm_pkg::WFM_DONE && broadcast_disable_hit && |filt_match);
    lowpower_c: cover property (cur.state == wfm_pkg::WFM_DONE && |filt_match && cur.ctrl[`WFM_CTL_LOWPOWER]);
endmodule // wfm_matcher
`default_nettype wire

// ==== design/wfm_params.svh ====
`ifndef WFM_PARAMS_SVH
`define WFM_PARAMS_SVH
// register offsets (byte addresses)
`define WFM_OFF_CTRL       8'h00
`define WFM_OFF_FILTER     8'h04
`define WFM_OFF_STATUS     8'h08
`define WFM_OFF_IRQ_EN     8'h0C
`define WFM_OFF_IRQ_CLR    8'h10
`define WFM_OFF_MAC_LO     8'h14
`define WFM_OFF_MAC_HI     8'h18
// control register fields
`define WFM_CTL_ENABLE     0
`define WFM_CTL_MAGIC      1
`define WFM_CTL_USE_PME    2
`define WFM_CTL_BROADCAST_DISABLE_DIS  3
`define WFM_CTL_LOWPOWER   4
// status fields
`define WFM_ST_FRAME_RX    0
// command fields
`define WFM_CMD_ENABLE     0
`define WFM_CMD_MCAST      3
// filter table layout
`define WFM_TABLE_WORDS    8
`define WFM_WORD_CMD       4
`define WFM_WORD_OFFSET    5
`define WFM_WORD_CRC01     6
`define WFM_WORD_CRC23     7
`define WFM_MASK_BITS      31
`define WFM_CRC_INIT       16'hFFFF
`define WFM_CRC_POLY       16'h8005
`define WFM_CTRL_RESET     32'h00000000
`endif

// ==== design/wfm_pkg.sv ====
`default_nettype none
package wfm_pkg;
    typedef enum logic [2:0] {
        WFM_IDLE = 3'b001,
        WFM_BODY = 3'b010,
        WFM_DONE = 3'b100
    } wfm_state_e;
endpackage
`default_nettype wire

// ==== sim/wfm_rx_model.sv ====
`default_nettype none
// receive datapath stand-in: one byte per cycle, sof on the first, eof on the last
module wfm_rx_model (
    input  wire logic       clk,
    output logic            rx_valid,
    output logic            rx_sof,
    output logic            rx_eof,
    output logic [7:0]      rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_valid = 1'h0;
        rx_sof   = 1'h0;
        rx_eof   = 1'h0;
        rx_data  = 8'h00;
    end
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(posedge clk);
            rx_valid <= 1'h1;
            rx_sof   <= (i == 0);
            rx_eof   <= (i == q.size() - 1);
            rx_data  <= q[i];
        end
        @(posedge clk);
        rx_valid <= 1'h0;
        rx_sof   <= 1'h0;
        rx_eof   <= 1'h0;
        rx_data  <= ~q[q.size() - 1];
    endtask
endmodule // wfm_rx_model
`default_nettype wire

// ==== sim/wakeup_frame_matcher_bench.sv ====
`include "wfm_params.svh"
`default_nettype none
module wakeup_frame_matcher_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [47:0] ST = 48'h0211_2233_4455;
    localparam logic [47:0] OT = 48'h0211_2233_4456;
    localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
    logic        clk, rst, clk_en, reg_wr, reg_rd, rx_valid, rx_sof, rx_eof;
    logic        rx_normal_enable, magic_detect_active, irq, power_event_output;
    logic [7:0]  reg_addr, rx_data;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [15:0] c0, c1, c2;
    logic [7:0]  fr[$];
    int          bad_count, comparisons;
    wfm_matcher u_dut (.clk(clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_sof(rx_sof),
        .rx_eof(rx_eof), .rx_data(rx_data), .rx_normal_enable(rx_normal_enable),
        .magic_detect_active(magic_detect_active), .irq(irq), .power_event_output(power_event_output));
    wfm_rx_model u_rx (.clk(clk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clk);
        reg_wr    <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clk);
        reg_rd   <= 1'h0;
        #1 d = reg_rdata;
    endtask
    // frame: destination, source, eight payload bytes counting up from b
    function automatic void mk(input logic [47:0] d, input logic [7:0] b);
        fr = {};
        for (int i = 0; i < 6; i++)
            fr.push_back(d[47 - 8 * i -: 8]);
        for (int i = 0; i < 6; i++)
            fr.push_back(8'hA0 + 8'(i));
        for (int i = 0; i < 8; i++)
            fr.push_back(b + 8'(i));
    endfunction
    function automatic logic [15:0] crc(input int off, input logic [30:0] m);
        logic [15:0] c;
        logic        fb;
        c = `WFM_CRC_INIT;
        for (int j = 0; j < 31; j++)
            if (m[j])
                for (int k = 0; k < 8; k++) begin
                    fb = c[15] ^ fr[off + j][k];
                    c  = {c[14:0], 1'h0} ^ (fb ? `WFM_CRC_POLY : 16'h0000);
                end
        return c;
    endfunction
    // send one frame with byte i flipped by f, check status, irq and power event, then clear
    task automatic fx(input logic [47:0] d, input logic [7:0] b, input int i, input logic [7:0] f,
                      input logic e, input logic ie, input logic pe);
        mk(d, b);
        fr[i] = fr[i] ^ f;
        u_rx.send(fr);
        repeat (4) @(posedge clk);
        rd(`WFM_OFF_STATUS, v);
        chk(v, {31'h0, e});
        chk({30'h0, irq, power_event_output}, {30'h0, ie, pe});
        wr(`WFM_OFF_IRQ_CLR, 32'h1);
    endtask
    task automatic t_load;
        mk(ST, 8'h10);
        c0 = crc(12, 31'h5);
        c1 = crc(14, 31'h3);
        mk(ST, 8'h40);
        c2 = crc(12, 31'h5);
        wr(`WFM_OFF_MAC_HI, 32'h0211);
        wr(`WFM_OFF_MAC_LO, 32'h2233_4455);
        wr(`WFM_OFF_IRQ_EN, 32'h1);
        // table loaded whole before detection is switched on, offsets all 12 or more
        wr(`WFM_OFF_FILTER, 32'h5);
        wr(`WFM_OFF_FILTER, 32'h3);
        wr(`WFM_OFF_FILTER, 32'h5);
        wr(`WFM_OFF_FILTER, 32'h0);
        wr(`WFM_OFF_FILTER, 32'h0800_0901);
        wr(`WFM_OFF_FILTER, 32'h100C_0E0C);
        wr(`WFM_OFF_FILTER, {c1, c0});
        wr(`WFM_OFF_FILTER, {16'h0, c2});
        rd(`WFM_OFF_FILTER, v);
        chk(v, 32'h0);
    endtask
    task automatic t_match;
        wr(`WFM_OFF_CTRL, 32'h1);
        #1 chk({31'h0, rx_normal_enable}, 32'h0);
        fx(ST, 8'h10, 0, 8'h00, 1'h1, 1'h1, 1'h0);
        #1 chk({31'h0, irq}, 32'h0);
        fx(ST, 8'h10, 13, 8'hFF, 1'h1, 1'h1, 1'h0);
        fx(ST, 8'h10, 14, 8'h01, 1'h0, 1'h0, 1'h0);
        fx(OT, 8'h10, 0, 8'h00, 1'h0, 1'h0, 1'h0);
        fx(ST, 8'h40, 0, 8'h00, 1'h0, 1'h0, 1'h0);
        fx(BC, 8'h10, 15, 8'hFF, 1'h0, 1'h0, 1'h0);
        wr(`WFM_OFF_CTRL, 32'h9);
        fx(BC, 8'h10, 0, 8'h00, 1'h1, 1'h1, 1'h0);
    endtask
    task automatic t_power;
        wr(`WFM_OFF_CTRL, 32'h5);
        fx(ST, 8'h10, 0, 8'h00, 1'h1, 1'h0, 1'h1);
        wr(`WFM_OFF_CTRL, 32'h0);
        @(posedge clk);
        #1 chk({30'h0, rx_normal_enable, power_event_output}, 32'h2);
        fx(ST, 8'h10, 0, 8'h00, 1'h0, 1'h0, 1'h0);
        wr(`WFM_OFF_CTRL, 32'h10);
        #1 chk({31'h0, magic_detect_active}, 32'h1);
        fx(ST, 8'h10, 0, 8'h00, 1'h1, 1'h1, 1'h0);
        wr(`WFM_OFF_CTRL, 32'h0);
        wr(`WFM_OFF_CTRL, 32'h2);
        #1 chk({30'h0, rx_normal_enable, magic_detect_active}, 32'h3);
        // a write while clk_en is low must not land
        @(posedge clk);
        clk_en <= 1'h0;
        wr(`WFM_OFF_CTRL, 32'h1);
        clk_en <= 1'h1;
        #1 chk({31'h0, rx_normal_enable}, 32'h1);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish;
    end
    initial begin
        rst       = 1'h1;
        clk_en    = 1'h1;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        bad_count = 0;
        comparisons = 0;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        #1 chk({29'h0, rx_normal_enable, irq, power_event_output}, 32'h4);
        t_load;
        t_match;
        t_power;
        tally_and_finish;
    end
endmodule // wakeup_frame_matcher_bench
`default_nettype wire
